// ===== core/dct_timer.v
// Decided for this implementation: register access over AXI4-Lite.
`include "dct_regs.vh"

// ==========================================================
// dual compare timer channel with axi4-lite register slave
// ==========================================================
module dct_timer (
  // clock, reset, clock enable
  input  wire                   aclk,
  input  wire                   aresetn,
  input  wire                   ce,
  // axi4-lite write address
  input  wire [`DCT_ADDR_W-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output reg                    s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output reg                    s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  // axi4-lite read address
  input  wire [`DCT_ADDR_W-1:0] s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output reg                    s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  // timer pins and neighbours
  input  wire                   timer_input_pin,
  input  wire                   input_pin_is_gpio,
  input  wire                   prescale_tick,
  output reg                    timer_output_pin,
  output reg                    count_irq
);

  // ==========================================================
  // state
  reg        in_meta_reg;
  reg        in_sync_reg;
  reg        in_prev_reg;
  reg [1:0]  div_reg;
  reg [15:0] count_reg;
  reg [15:0] limit_a_reg;
  reg [15:0] limit_b_reg;
  reg [15:0] t1_control_reg;
  reg        en_reg;
  reg        int_reg;
  reg        riu_reg;
  reg        mc_reg;
  reg        rtg_reg;
  reg        pre_reg;
  reg        ext_reg;
  reg        alt_reg;
  reg        free_run_select_reg;

  // write channel holding
  reg                   aw_got_reg;
  reg                   w_got_reg;
  reg [`DCT_ADDR_W-1:0] aw_addr_reg;
  reg [31:0]            w_data_reg;
  reg [3:0]             w_strb_reg;

  // next values
  reg [15:0] count_next;
  reg        en_next;
  reg        riu_next;
  reg        mc_next;
  reg        out_next;
  reg        irq_next;
  reg        match;

  // ==========================================================
  // byte lane merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] data;
    input [1:0]  strb;
    begin
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  // ==========================================================
  // input pin qualification
  wire in_eff;
  wire in_rise;
  wire tick4;
  wire int_tick;
  wire advance;
  wire retrig;

  // a gpio-assigned pin reads as constant high internally
  assign in_eff  = input_pin_is_gpio | in_sync_reg;
  assign in_rise = in_eff & ~in_prev_reg;
  assign tick4   = (div_reg == `DCT_DIV_LAST);
  assign int_tick = pre_reg ? prescale_tick : tick4;

  // external mode takes only pin edges, prescaler select is a don't care there
  assign advance = en_reg & (ext_reg ? in_rise
                                     : (int_tick & (rtg_reg | in_eff)));
  // retrigger only applies with the internal clock
  assign retrig  = en_reg & ~ext_reg & rtg_reg & in_rise;

  // ==========================================================
  // compare selection
  wire [15:0] limit_sel;
  wire [15:0] limit_eff;
  wire [15:0] count_inc;

  assign limit_sel = riu_reg ? limit_b_reg : limit_a_reg;
  // a zero limit behaves as a limit of 16'hFFFF, so the count wraps after 16'hFFFE
  assign limit_eff = (limit_sel == `DCT_COUNT_ZERO) ? `DCT_COUNT_MAX : limit_sel;
  assign count_inc = count_reg + 16'h0001;

  // ==========================================================
  // bus decode
  wire       aw_hs;
  wire       w_hs;
  wire       ar_hs;
  wire       aw_got_now;
  wire       w_got_now;
  wire       do_wr;
  wire [9:0] wr_idx;
  wire [9:0] rd_idx;
  wire [15:0] wr_data;
  wire [1:0]  wr_strb;
  wire       wr_ctl;
  wire       wr_cnt;
  wire       wr_hit;

  assign aw_hs      = s_axi_awvalid & s_axi_awready;
  assign w_hs       = s_axi_wvalid & s_axi_wready;
  assign ar_hs      = s_axi_arvalid & s_axi_arready;
  assign aw_got_now = aw_got_reg | aw_hs;
  assign w_got_now  = w_got_reg | w_hs;
  // a write commits once both halves are held and the last response is gone
  assign do_wr      = aw_got_reg & w_got_reg & ~s_axi_bvalid;
  assign wr_idx     = aw_addr_reg[11:2];
  assign rd_idx     = s_axi_araddr[11:2];
  assign wr_data    = w_data_reg[15:0];
  assign wr_strb    = w_strb_reg[1:0];
  assign wr_ctl     = do_wr & (wr_idx == `DCT_IDX_CONTROL);
  assign wr_cnt     = do_wr & (wr_idx == `DCT_IDX_COUNT);
  assign wr_hit     = (wr_idx == `DCT_IDX_CONTROL) | (wr_idx == `DCT_IDX_COUNT) |
                      (wr_idx == `DCT_IDX_LIMIT_A) | (wr_idx == `DCT_IDX_LIMIT_B) |
                      (wr_idx == `DCT_IDX_T1_CONTROL);

  // ==========================================================
  // timer next state
  always @* begin
    count_next = count_reg;
    en_next    = en_reg;
    riu_next   = riu_reg;
    mc_next    = mc_reg;
    out_next   = timer_output_pin;
    irq_next   = 1'b0;
    match      = 1'b0;
    // with the timer disabled nothing below advances, so state holds except the single mode output, which returns high
    if (retrig) begin
      count_next = `DCT_COUNT_ZERO;
    end else if (advance) begin
      if (count_inc == limit_eff) begin
        match      = 1'b1;
        count_next = `DCT_COUNT_ZERO;
        mc_next    = 1'b1;
        irq_next   = int_reg;
        if (alt_reg) begin
          riu_next = ~riu_reg;
        end
        // one-shot: dual mode halts only after the B phase
        if (!free_run_select_reg && (!alt_reg || riu_reg)) begin
          en_next  = 1'b0;
          riu_next = 1'b0;
        end
      end else begin
        count_next = count_inc;
      end
    end
    // output waveform; without a match single mode drives high, dual mode drives ~riu_reg while enabled and holds while disabled
    if (match) begin
      out_next = alt_reg ? ~riu_next : 1'b0;
    end else if (alt_reg) begin
      if (en_reg) begin
        out_next = ~riu_reg;
      end
    end else begin
      out_next = 1'b1;
    end
    // software effects; a hardware set of the flag wins over a clear
    if (wr_ctl) begin
      if (wr_strb[1] && wr_data[`DCT_BIT_QUAL]) begin
        en_next = wr_data[`DCT_BIT_EN];
      end
      if (wr_strb[0] && !wr_data[`DCT_BIT_MC] && !match) begin
        mc_next = 1'b0;
      end
    end
    // a count write wins over the advance in the same cycle
    if (wr_cnt) begin
      count_next = merge16(count_reg, wr_data, wr_strb);
    end
  end

  // ==========================================================
  // timer registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      in_meta_reg      <= 1'b0;
      in_sync_reg      <= 1'b0;
      in_prev_reg      <= 1'b0;
      div_reg          <= 2'h0;
      count_reg        <= `DCT_RST_COUNT;
      en_reg           <= 1'b0;
      riu_reg          <= 1'b0;
      mc_reg           <= 1'b0;
      timer_output_pin <= 1'b1;
      count_irq        <= 1'b0;
    end else if (ce) begin
      in_meta_reg      <= timer_input_pin;
      in_sync_reg      <= in_meta_reg;
      in_prev_reg      <= in_eff;
      div_reg          <= div_reg + 2'h1;
      count_reg        <= count_next;
      en_reg           <= en_next;
      riu_reg          <= riu_next;
      mc_reg           <= mc_next;
      timer_output_pin <= out_next;
      count_irq        <= irq_next;
    end
  end

  // ==========================================================
  // configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      limit_a_reg    <= `DCT_RST_LIMIT;
      limit_b_reg    <= `DCT_RST_LIMIT;
      t1_control_reg <= `DCT_RST_T1_CONTROL;
      int_reg        <= 1'b0;
      rtg_reg        <= 1'b0;
      pre_reg        <= 1'b0;
      ext_reg        <= 1'b0;
      alt_reg        <= 1'b0;
      free_run_select_reg       <= 1'b0;
    end else if (ce && do_wr) begin
      if (wr_idx == `DCT_IDX_LIMIT_A) begin
        limit_a_reg <= merge16(limit_a_reg, wr_data, wr_strb);
      end
      if (wr_idx == `DCT_IDX_LIMIT_B) begin
        limit_b_reg <= merge16(limit_b_reg, wr_data, wr_strb);
      end
      if (wr_idx == `DCT_IDX_T1_CONTROL) begin
        t1_control_reg <= merge16(t1_control_reg, wr_data, wr_strb);
      end
      if (wr_idx == `DCT_IDX_CONTROL) begin
        if (wr_strb[1]) begin
          int_reg <= wr_data[`DCT_BIT_INT];
        end
        if (wr_strb[0]) begin
          rtg_reg  <= wr_data[`DCT_BIT_RTG];
          pre_reg  <= wr_data[`DCT_BIT_PRE];
          ext_reg  <= wr_data[`DCT_BIT_EXT];
          alt_reg  <= wr_data[`DCT_BIT_ALT];
          free_run_select_reg <= wr_data[`DCT_BIT_FREE_RUN_SELECT];
        end
      end
    end
  end

  // ==========================================================
  // axi4-lite write channels
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      aw_addr_reg   <= {`DCT_ADDR_W{1'b0}};
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DCT_RESP_OKAY;
    end else if (ce) begin
      if (aw_hs) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_reg    <= 1'b0;
        w_got_reg     <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_hit ? `DCT_RESP_OKAY : `DCT_RESP_SLVERR;
      end else begin
        // each half is taken alone and held until its partner arrives
        aw_got_reg    <= aw_got_now;
        w_got_reg     <= w_got_now;
        s_axi_awready <= ~aw_got_now;
        s_axi_wready  <= ~w_got_now;
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // axi4-lite read channels
  reg [15:0] rd_word;
  reg        rd_hit;

  always @* begin
    rd_word = 16'h0000;
    rd_hit  = 1'b1;
    case (rd_idx)
      `DCT_IDX_CONTROL: begin
        // the qualifier always reads back as zero
        rd_word = {en_reg, 1'b0, int_reg, riu_reg, 6'h00,
                   mc_reg, rtg_reg, pre_reg, ext_reg, alt_reg, free_run_select_reg};
      end
      `DCT_IDX_COUNT: begin
        rd_word = count_reg;
      end
      `DCT_IDX_LIMIT_A: begin
        rd_word = limit_a_reg;
      end
      `DCT_IDX_LIMIT_B: begin
        rd_word = limit_b_reg;
      end
      `DCT_IDX_T1_CONTROL: begin
        rd_word = t1_control_reg;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `DCT_RESP_OKAY;
    end else if (ce) begin
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {16'h0000, rd_word};
        s_axi_rresp   <= rd_hit ? `DCT_RESP_OKAY : `DCT_RESP_SLVERR;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid  <= 1'b0;
          s_axi_arready <= 1'b1;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ===== core/dct_regs.vh
`ifndef DCT_REGS_VH
`define DCT_REGS_VH

// ==========================================================
// register indices (byte address = index * 4)
`define DCT_IDX_CONTROL    10'h340
`define DCT_IDX_COUNT      10'h342
`define DCT_IDX_LIMIT_A    10'h344
`define DCT_IDX_LIMIT_B    10'h346
`define DCT_IDX_T1_CONTROL 10'h348
`define DCT_ADDR_W         12

// ==========================================================
// timer0_control field positions
`define DCT_BIT_EN    15
`define DCT_BIT_QUAL  14
`define DCT_BIT_INT   13
`define DCT_BIT_RIU   12
`define DCT_BIT_MC    5
`define DCT_BIT_RTG   4
`define DCT_BIT_PRE   3
`define DCT_BIT_EXT   2
`define DCT_BIT_ALT   1
`define DCT_BIT_FREE_RUN_SELECT  0

// ==========================================================
// reset values
`define DCT_RST_CONTROL    16'h0000
`define DCT_RST_COUNT      16'h0000
`define DCT_RST_LIMIT      16'h0000
`define DCT_RST_T1_CONTROL 16'h0000

// ==========================================================
// counting and timing
`define DCT_COUNT_ZERO 16'h0000
`define DCT_COUNT_MAX  16'hFFFF
`define DCT_DIV_LAST   2'h3

// ==========================================================
// bus answers
`define DCT_RESP_OKAY   2'h0
`define DCT_RESP_SLVERR 2'h2

`endif

// ===== tb/dct_event_src.sv
// ====
// external event source on the timer input pin
module dct_event_src (
  // clock
  input  logic aclk,
  // control from the bench
  input  logic burst,
  input  logic level,
  // pin
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_reg = 2'h0;
  initial pin = 1'b0;
  // a burst toggles every 4 clocks, so edges never come faster than clk/4
  always @(posedge aclk) begin
    div_reg <= burst ? div_reg + 2'h1 : 2'h0;
    if (!burst)
      pin <= level;
    else if (div_reg == 2'h3)
      pin <= !pin;
  end
endmodule

// ===== tb/dct_timer_monitor.sv
`include "dct_regs.vh"

// ====
// port checker
module dct_timer_monitor (
  // clock and reset
  input logic                   aclk,
  input logic                   aresetn,
  // register bus
  input logic [`DCT_ADDR_W-1:0] s_axi_awaddr,
  input logic                   s_axi_awvalid,
  input logic                   s_axi_awready,
  input logic [31:0]            s_axi_wdata,
  input logic                   s_axi_wvalid,
  input logic                   s_axi_wready,
  input logic                   s_axi_bvalid,
  input logic                   s_axi_arvalid,
  input logic                   s_axi_arready,
  input logic [31:0]            s_axi_rdata,
  input logic                   s_axi_rvalid,
  input logic                   s_axi_rready,
  // timer pins
  input logic                   timer_output_pin,
  input logic                   count_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // mode shadow caught at the handshake; only valid while a halted timer is reconfigured
  logic dual_reg;
  logic irqen_reg;
  wire  ctl_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                   && s_axi_awaddr == {`DCT_IDX_CONTROL, 2'b00};
  always @(posedge aclk) begin
    if (!aresetn) begin
      dual_reg  <= 1'b0;
      irqen_reg <= 1'b0;
    end else if (ctl_take) begin
      dual_reg  <= s_axi_wdata[`DCT_BIT_ALT];
      irqen_reg <= s_axi_wdata[`DCT_BIT_INT];
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer;
    s_wr_take |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("read answer repeated");
  property p_rd_upper;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_single_pulse;
    !dual_reg && $fell(timer_output_pin) |=> timer_output_pin;
  endproperty
  a_single_pulse: assert property (p_single_pulse) else $error("output low too long");
  property p_single_match;
    !dual_reg && count_irq |-> !timer_output_pin;
  endproperty
  a_single_match: assert property (p_single_match) else $error("no output pulse at match");
  property p_irq_gate;
    count_irq |-> irqen_reg;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request while masked");
  property p_dual_flip;
    dual_reg && count_irq |-> $changed(timer_output_pin);
  endproperty
  a_dual_flip: assert property (p_dual_flip) else $error("output kept at phase change");
endmodule

bind dct_timer dct_timer_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .timer_output_pin(timer_output_pin), .count_irq(count_irq)
);

// ===== tb/testbench.sv
`include "dct_regs.vh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, gpio, ptick, burst, level, pin, tout, irq, ce;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic [1:0]  bresp, rresp, wr_resp, rd_resp;
  logic [15:0] hold;
  int          failures = 0, tests_run = 0, irq_n = 0, k;

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  dct_timer dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_input_pin(pin), .input_pin_is_gpio(gpio), .prescale_tick(ptick),
    .timer_output_pin(tout), .count_irq(irq));
  dct_event_src src (.aclk(aclk), .burst(burst), .level(level), .pin(pin));

  always @(posedge aclk) if (irq === 1'b1) irq_n <= irq_n + 1;

  // ====
  // bus tasks and checks
  task results;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task tmo(input int n);
    if (n >= 60) begin
      failures++;
      $display("wrong value at %0t: no answer", $time);
      results();
    end
  endtask
  task chk(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [9:0] i, input logic [15:0] d);
    int n;
    logic a, w;
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    a = 1'b0;
    w = 1'b0;
    n = 0;
    while (!(a && w) && n < 60) begin
      @(posedge aclk);
      n++;
      if (!a && awready === 1'b1) begin a = 1'b1; awvalid <= 1'b0; end
      if (!w && wready === 1'b1) begin w = 1'b1; wvalid <= 1'b0; end
    end
    tmo(n);
    n = 0;
    do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 60);
    tmo(n);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [9:0] i);
    int n;
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 60);
    arvalid <= 1'b0;
    tmo(n);
    n = 0;
    do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 60);
    tmo(n);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask
  task rc(input logic [9:0] i, input logic [31:0] m, e);
    rd(i);
    chk(rd_data & m, e);
  endtask
  task cw(input logic [15:0] d);
    wr(`DCT_IDX_CONTROL, d);
  endtask
  task wait_off;
    int n;
    n = 0;
    do begin rd(`DCT_IDX_CONTROL); n++; end while (rd_data[15] !== 1'b0 && n < 60);
    tmo(n);
  endtask
  task ticks(input int n);
    repeat (n) begin
      @(posedge aclk);
      ptick <= 1'b1;
      @(posedge aclk);
      ptick <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask
  // four rising edges, then let the synchroniser settle
  task pulse_burst;
    @(posedge aclk);
    burst <= 1'b1;
    repeat (32) @(posedge aclk);
    burst <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  // ====
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ptick, burst, level} = 9'h000;
    {awaddr, araddr, wdata} = 56'h0;
    gpio = 1'b1;
    ce = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 5; k++) rc(`DCT_IDX_CONTROL + 10'(2 * k), 32'hFFFFFFFF, 32'h0);
    wr(`DCT_IDX_LIMIT_B, 16'hA5C3);
    chk(wr_resp, `DCT_RESP_OKAY);
    rc(`DCT_IDX_LIMIT_B, 32'hFFFFFFFF, 32'hA5C3);
    chk(rd_resp, `DCT_RESP_OKAY);
    wr(10'h3F0, 16'hFFFF);
    chk(wr_resp, `DCT_RESP_SLVERR);
    rc(10'h3F0, 32'hFFFFFFFF, 32'h0);
    chk(rd_resp, `DCT_RESP_SLVERR);
    cw(16'h8000);
    rc(`DCT_IDX_CONTROL, 32'hFFFF, 32'h0);
    $display("test registers finished");
    wr(`DCT_IDX_LIMIT_A, 16'h0003);
    cw(16'hC000);
    wait_off();
    rc(`DCT_IDX_CONTROL, 32'hFFFF, 32'h0020);
    rc(`DCT_IDX_COUNT, 32'hFFFF, 32'h0);
    chk(irq_n, 32'h0);
    cw(16'h0000);
    rc(`DCT_IDX_CONTROL, 32'hFFFF, 32'h0);
    cw(16'h0020);
    rc(`DCT_IDX_CONTROL, 32'hFFFF, 32'h0);
    $display("test one shot finished");
    wr(`DCT_IDX_LIMIT_A, 16'h0002);
    wr(`DCT_IDX_LIMIT_B, 16'h0003);
    cw(16'hE002);
    k = 0;
    while (tout !== 1'b0 && k < 60) begin @(posedge aclk); k++; end
    tmo(k);
    rc(`DCT_IDX_CONTROL, 32'h9000, 32'h9000);
    wait_off();
    rc(`DCT_IDX_CONTROL, 32'hFFFF, 32'h2022);
    chk(irq_n, 32'h2);
    chk(tout, 32'h1);
    $display("test dual finished");
    cw(16'hE009);
    ticks(5);
    rc(`DCT_IDX_COUNT, 32'hFFFF, 32'h1);
    chk(irq_n, 32'h4);
    rc(`DCT_IDX_CONTROL, 32'h8000, 32'h8000);
    cw(16'h4000);
    gpio <= 1'b0;
    wr(`DCT_IDX_COUNT, 16'h0000);
    wr(`DCT_IDX_LIMIT_A, 16'h0100);
    cw(16'hC01D);
    fork
      pulse_burst();
      ticks(8);
    join
    rc(`DCT_IDX_COUNT, 32'hFFFF, 32'h4);
    repeat (40) @(posedge aclk);
    rc(`DCT_IDX_COUNT, 32'hFFFF, 32'h4);
    chk(tout, 32'h1);
    cw(16'h4000);
    gpio <= 1'b1;
    cw(16'hC01D);
    pulse_burst();
    rc(`DCT_IDX_COUNT, 32'hFFFF, 32'h4);
    $display("test external finished");
    cw(16'h4000);
    gpio <= 1'b0;
    wr(`DCT_IDX_LIMIT_A, 16'h0000);
    cw(16'hC001);
    repeat (40) @(posedge aclk);
    rc(`DCT_IDX_COUNT, 32'hFFFF, 32'h4);
    level <= 1'b1;
    repeat (40) @(posedge aclk);
    // a low clock enable must freeze the running count
    rd(`DCT_IDX_COUNT);
    hold = rd_data[15:0];
    ce <= 1'b0;
    repeat (40) @(posedge aclk);
    ce <= 1'b1;
    rd(`DCT_IDX_COUNT);
    chk({31'h0, rd_data[15:0] - hold < 16'h0004}, 32'h1);
    cw(16'h4001);
    rd(`DCT_IDX_COUNT);
    hold = rd_data[15:0];
    repeat (20) @(posedge aclk);
    rc(`DCT_IDX_COUNT, 32'hFFFF, {16'h0000, hold});
    chk({31'h0, hold > 16'h0004}, 32'h1);
    cw(16'hC011);
    wr(`DCT_IDX_COUNT, 16'h1234);
    rd(`DCT_IDX_COUNT);
    chk({31'h0, rd_data[15:0] - 16'h1234 < 16'h0004}, 32'h1);
    level <= 1'b0;
    repeat (8) @(posedge aclk);
    level <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(`DCT_IDX_COUNT);
    chk({31'h0, rd_data[15:0] < 16'h0004}, 32'h1);
    cw(16'h4000);
    wr(`DCT_IDX_COUNT, 16'hFFFC);
    cw(16'hC000);
    wait_off();
    rc(`DCT_IDX_COUNT, 32'hFFFF, 32'h0);
    rc(`DCT_IDX_CONTROL, 32'hFFFF, 32'h0020);
    $display("test gate and load finished");
    results();
  end
endmodule
